// File: logic/pacc_edge_tick.sv
// conversion-clock tick: external pin rising edge or internal divider
`timescale 1ns/1ps
module pacc_edge_tick #(
  parameter int unsigned DIV = 4
) (
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  input  wire logic clk_en_in,
  input  wire logic use_internal_in,
  input  wire logic ext_clk_sync_in,
  output logic      tick_out
);
  logic       ext_prev_q;
  logic [7:0] div_q;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_prev_q <= 1'b0;
      div_q      <= 8'h00;
      tick_out   <= 1'b0;
    end else if (clk_en_in) begin
      ext_prev_q <= ext_clk_sync_in;
      if (div_q >= 8'(DIV - 1)) begin
        div_q <= 8'h00;
      end else begin
        div_q <= div_q + 8'h01;
      end
      if (use_internal_in) begin
        tick_out <= (div_q >= 8'(DIV - 1));
      end else begin
        tick_out <= ext_clk_sync_in & ~ext_prev_q;
      end
    end
  end
endmodule

// File: logic/pacc_pkg.sv
// package: constants and types for the parallel converter control block
package pacc_pkg;

  // ****************************************
  // control byte field positions
  // ****************************************
  localparam int unsigned CTRL_W        = 8;
  localparam int unsigned PD_HI_BIT     = 7;
  localparam int unsigned PD_LO_BIT     = 6;
  localparam int unsigned ACQ_EXT_BIT   = 5;
  localparam int unsigned RANGE_BIT     = 4;
  localparam int unsigned BIPOLAR_BIT   = 3;
  localparam int unsigned CHAN_MSB      = 2;
  localparam int unsigned CHAN_LSB      = 0;
  localparam int unsigned RESULT_W      = 12;
  localparam int unsigned NUM_CHANNELS  = 6;

  // ****************************************
  // timing counts in conversion-clock cycles
  // ****************************************
  localparam int unsigned ACQ_CYCLES    = 6;
  localparam int unsigned CONV_CYCLES   = 12;
  localparam int unsigned CNT_W         = 4;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [11:0] RESULT_RESET  = 12'h000;

  // ****************************************
  // power/clock mode codes
  // ****************************************
  localparam logic [1:0]  PD_NORMAL_EXT = 2'h0;
  localparam logic [1:0]  PD_NORMAL_INT = 2'h1;
  localparam logic [1:0]  PD_STANDBY    = 2'h2;
  localparam logic [1:0]  PD_FULL       = 2'h3;

  typedef enum logic [1:0] {
    PACC_IDLE    = 2'b00,
    PACC_ACQUIRE = 2'b01,
    PACC_CONVERT = 2'b11
  } pacc_state_t;

  typedef enum logic [1:0] {
    PACC_PWR_NORMAL  = 2'b00,
    PACC_PWR_STANDBY = 2'b01,
    PACC_PWR_FULL    = 2'b11
  } pacc_power_t;

  typedef struct packed {
    logic [1:0] power_clock_sel;
    logic       acquisition_mode_ext;
    logic       range_full_scale;
    logic       bipolar_select;
    logic [2:0] channel_sel;
  } pacc_ctrl_t;

endpackage

// File: logic/pacc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pacc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  input  wire logic clk_en_in,
  input  wire logic pin_in,
  output logic      sync_out
);
  logic meta_q;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else if (clk_en_in) begin
      meta_q   <= pin_in;
      sync_out <= meta_q;
    end
  end
endmodule

// File: logic/pacc_top.sv
// top: bus interface, sequencing and result path of the converter control
// Contract
// - done output goes low when conversion finishes and result is readable
// - done output returns high on first read or on a new control write
// - read strobe falling edge with chip select low drives result onto bus
// - chip select high ignores strobes and releases the data bus
// - control byte captured from the low eight data lines on a write
// - internal mode: write rising edge latches config, starts acquire then convert
// - internal acquisition lasts six conversion-clock cycles, then hold and convert
// - external mode: first write starts acquisition, second ends it and converts
// - second byte with external bit clear converts; set restarts open acquisition
// - bit 5 picks internal six-cycle or external acquisition
// - bits 7..6 pick clock and power mode; power-down keeps clock mode
// - bits 4 and 3 pick range magnitude and polarity
// - bits 2..0 pick channel zero through five
// - every conversion takes twelve conversion-clock cycles
// - write during conversion aborts it and starts new acquisition
// - sample taken at the end of the acquisition interval
// - result straight binary unipolar, two's complement bipolar
// - at reset done is high and external clock normal mode selected
// - power-down waits for conversion end; bus stays usable; write restores normal
`timescale 1ns/1ps
module pacc_top #(
  parameter int unsigned INT_CLK_DIV = 4
) (
  input  wire logic                              clk_sys_in,
  input  wire logic                              reset_n_in,
  input  wire logic                              clk_en_in,
  input  wire logic                              chip_select_n_in,
  input  wire logic                              read_n_in,
  input  wire logic                              write_n_in,
  input  wire logic                              conv_clk_in,
  input  wire logic [pacc_pkg::RESULT_W-1:0]     data_bus_full_in,
  input  wire logic [pacc_pkg::NUM_CHANNELS*pacc_pkg::RESULT_W-1:0] analog_inputs_in,
  output logic      [pacc_pkg::RESULT_W-1:0]     data_bus_full_out,
  output logic                                   data_bus_oe_out,
  output logic                                   conv_done_n_out,
  output logic                                   tracking_out,
  output logic      [pacc_pkg::NUM_CHANNELS-1:0] channel_onehot_out,
  output logic      [1:0]                        range_sel_out,
  output logic      [1:0]                        power_state_out
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic cclk_s;
  logic tick;

  pacc_sync #(.RESET_VAL(1'b1)) u_sync_cs (
    .clk_sys_in (clk_sys_in), .reset_n_in (reset_n_in), .clk_en_in (clk_en_in),
    .pin_in     (chip_select_n_in), .sync_out (cs_n_s));
  pacc_sync #(.RESET_VAL(1'b1)) u_sync_rd (
    .clk_sys_in (clk_sys_in), .reset_n_in (reset_n_in), .clk_en_in (clk_en_in),
    .pin_in     (read_n_in), .sync_out (rd_n_s));
  pacc_sync #(.RESET_VAL(1'b1)) u_sync_wr (
    .clk_sys_in (clk_sys_in), .reset_n_in (reset_n_in), .clk_en_in (clk_en_in),
    .pin_in     (write_n_in), .sync_out (wr_n_s));
  pacc_sync #(.RESET_VAL(1'b0)) u_sync_cclk (
    .clk_sys_in (clk_sys_in), .reset_n_in (reset_n_in), .clk_en_in (clk_en_in),
    .pin_in     (conv_clk_in), .sync_out (cclk_s));

  // data and analog pins pass two flops on every enabled cycle too, matching the two-cycle lag of the strobes
  logic [pacc_pkg::CTRL_W-1:0] data_s1_q;
  logic [pacc_pkg::CTRL_W-1:0] data_s2_q;
  logic [pacc_pkg::NUM_CHANNELS*pacc_pkg::RESULT_W-1:0] ain_s1_q;
  logic [pacc_pkg::NUM_CHANNELS*pacc_pkg::RESULT_W-1:0] ain_s2_q;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_s1_q <= pacc_pkg::CTRL_RESET;
      data_s2_q <= pacc_pkg::CTRL_RESET;
      ain_s1_q  <= '0;
      ain_s2_q  <= '0;
    end else if (clk_en_in) begin
      data_s1_q <= data_bus_full_in[pacc_pkg::CTRL_W-1:0];
      data_s2_q <= data_s1_q;
      ain_s1_q  <= analog_inputs_in;
      ain_s2_q  <= ain_s1_q;
    end
  end

  // ****************************************
  // strobe edges
  // ****************************************
  logic rd_prev_q;
  logic wr_prev_q;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
    end else if (clk_en_in) begin
      rd_prev_q <= rd_n_s;
      wr_prev_q <= wr_n_s;
    end
  end

  logic rd_fall;
  logic wr_rise;
  logic wr_fall;
  assign rd_fall = !cs_n_s && !rd_n_s && rd_prev_q;
  assign wr_rise = !cs_n_s && wr_n_s && !wr_prev_q;
  assign wr_fall = !cs_n_s && !wr_n_s && wr_prev_q;

  // ****************************************
  // control byte
  // ****************************************
  pacc_pkg::pacc_ctrl_t ctrl_q;
  pacc_pkg::pacc_ctrl_t new_ctrl;
  assign new_ctrl = pacc_pkg::pacc_ctrl_t'(data_s2_q);

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_q <= pacc_pkg::pacc_ctrl_t'(pacc_pkg::CTRL_RESET);
    end else if (clk_en_in && wr_rise) begin
      ctrl_q <= new_ctrl;
    end
  end

  // clock mode only follows normal-mode codes; power-down codes leave it
  logic int_clk_q;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      int_clk_q <= 1'b0;
    end else if (clk_en_in && wr_rise) begin
      if (new_ctrl.power_clock_sel == pacc_pkg::PD_NORMAL_EXT) begin
        int_clk_q <= 1'b0;
      end else if (new_ctrl.power_clock_sel == pacc_pkg::PD_NORMAL_INT) begin
        int_clk_q <= 1'b1;
      end
    end
  end

  pacc_edge_tick #(.DIV(INT_CLK_DIV)) u_tick (
    .clk_sys_in      (clk_sys_in),
    .reset_n_in      (reset_n_in),
    .clk_en_in       (clk_en_in),
    .use_internal_in (int_clk_q),
    .ext_clk_sync_in (cclk_s),
    .tick_out        (tick));

  // ****************************************
  // sequencer
  // ****************************************
  pacc_pkg::pacc_state_t      state_q;
  logic [pacc_pkg::CNT_W-1:0] cnt_q;
  logic                       conv_end;
  assign conv_end = (state_q == pacc_pkg::PACC_CONVERT) && tick
                    && (cnt_q == pacc_pkg::CNT_W'(pacc_pkg::CONV_CYCLES - 1));

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= pacc_pkg::PACC_IDLE;
      cnt_q   <= '0;
    end else if (clk_en_in) begin
      if (wr_rise) begin
        cnt_q <= '0;
        if (state_q == pacc_pkg::PACC_ACQUIRE && ctrl_q.acquisition_mode_ext
            && !new_ctrl.acquisition_mode_ext) begin
          state_q <= pacc_pkg::PACC_CONVERT;
        end else begin
          state_q <= pacc_pkg::PACC_ACQUIRE;
        end
      end else if (tick) begin
        unique case (state_q)
          pacc_pkg::PACC_IDLE: begin
            cnt_q <= '0;
          end
          pacc_pkg::PACC_ACQUIRE: begin
            if (!ctrl_q.acquisition_mode_ext) begin
              if (cnt_q == pacc_pkg::CNT_W'(pacc_pkg::ACQ_CYCLES - 1)) begin
                cnt_q   <= '0;
                state_q <= pacc_pkg::PACC_CONVERT;
              end else begin
                cnt_q <= cnt_q + 1'b1;
              end
            end
          end
          pacc_pkg::PACC_CONVERT: begin
            if (conv_end) begin
              cnt_q   <= '0;
              state_q <= pacc_pkg::PACC_IDLE;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // sample and result
  // ****************************************
  logic                                hold_entry;
  logic [pacc_pkg::RESULT_W-1:0]       sample_q;
  logic [pacc_pkg::RESULT_W-1:0]       result_q;
  logic [pacc_pkg::RESULT_W-1:0]       chan_val;
  logic [2:0]                          chan;

  assign hold_entry = (state_q == pacc_pkg::PACC_ACQUIRE) && (!wr_rise || new_ctrl.acquisition_mode_ext
                      ? (tick && !ctrl_q.acquisition_mode_ext && !wr_rise
                         && cnt_q == pacc_pkg::CNT_W'(pacc_pkg::ACQ_CYCLES - 1))
                      : ctrl_q.acquisition_mode_ext);
  assign chan = ctrl_q.channel_sel;

  // reserved codes read as zero input
  always_comb begin
    chan_val = '0;
    if (chan < 3'(pacc_pkg::NUM_CHANNELS)) begin
      chan_val = ain_s2_q[chan*pacc_pkg::RESULT_W +: pacc_pkg::RESULT_W];
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sample_q <= pacc_pkg::RESULT_RESET;
    end else if (clk_en_in && hold_entry) begin
      sample_q <= chan_val;
    end
  end

  // inputs arrive as offset binary; bipolar flips msb into two's complement
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      result_q <= pacc_pkg::RESULT_RESET;
    end else if (clk_en_in && conv_end && !wr_rise) begin
      result_q <= ctrl_q.bipolar_select
                  ? {~sample_q[pacc_pkg::RESULT_W-1], sample_q[pacc_pkg::RESULT_W-2:0]}
                  : sample_q;
    end
  end

  // ****************************************
  // done flag and bus driver
  // ****************************************
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      conv_done_n_out <= 1'b1;
    end else if (clk_en_in) begin
      if (conv_end && !wr_rise) begin
        conv_done_n_out <= 1'b0;
      end else if (rd_fall || wr_rise) begin
        conv_done_n_out <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_bus_oe_out   <= 1'b0;
      data_bus_full_out <= pacc_pkg::RESULT_RESET;
    end else if (clk_en_in) begin
      if (cs_n_s || rd_n_s) begin
        data_bus_oe_out <= 1'b0;
      end else if (rd_fall) begin
        data_bus_oe_out   <= 1'b1;
        data_bus_full_out <= result_q;
      end
    end
  end

  // ****************************************
  // mode outputs and power state
  // ****************************************
  logic pd_pending_q;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pd_pending_q    <= 1'b0;
      power_state_out <= pacc_pkg::PACC_PWR_NORMAL;
    end else if (clk_en_in) begin
      if (wr_fall) begin
        power_state_out <= pacc_pkg::PACC_PWR_NORMAL;
      end
      if (wr_rise) begin
        pd_pending_q <= new_ctrl.power_clock_sel[1];
      end else if (pd_pending_q && state_q == pacc_pkg::PACC_IDLE && !wr_fall) begin
        // a write already starting keeps the device awake
        pd_pending_q    <= 1'b0;
        power_state_out <= (ctrl_q.power_clock_sel == pacc_pkg::PD_FULL)
                           ? pacc_pkg::PACC_PWR_FULL : pacc_pkg::PACC_PWR_STANDBY;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tracking_out       <= 1'b0;
      channel_onehot_out <= '0;
      range_sel_out      <= 2'h0;
    end else if (clk_en_in) begin
      tracking_out       <= (state_q == pacc_pkg::PACC_ACQUIRE);
      channel_onehot_out <= (chan < 3'(pacc_pkg::NUM_CHANNELS))
                            ? pacc_pkg::NUM_CHANNELS'(6'h01 << chan) : '0;
      range_sel_out      <= {ctrl_q.bipolar_select, ctrl_q.range_full_scale};
    end
  end

endmodule

// File: sim/pacc_host_model.sv
// host model: processor side of the parallel bus and the conversion clock pin
`timescale 1ns/1ps
module pacc_host_model (
  input  wire logic        clk_sys_in,
  input  wire logic [11:0] bus_q_in,
  input  wire logic        bus_oe_in,
  output logic             cs_n_out,
  output logic             rd_n_out,
  output logic             wr_n_out,
  output logic             cclk_out,
  output logic [11:0]      bus_d_out
);
  // ********
  // strobes, released data and clock source
  // ********
  logic [1:0] div_q;
  initial begin
    {cs_n_out, rd_n_out, wr_n_out, cclk_out} = 4'hf;
    bus_d_out = 12'h5a5;
    div_q = 2'h0;
  end
  // free-running pin clock, eight system clocks a period
  always @(posedge clk_sys_in) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) cclk_out <= ~cclk_out;
  end
  // upper nibble set on purpose: only the low byte may be taken
  task automatic write_ctrl(input logic [7:0] b);
    @(posedge clk_sys_in);
    cs_n_out  <= 1'b0;
    wr_n_out  <= 1'b0;
    bus_d_out <= {4'hf, b};
    repeat (4) @(posedge clk_sys_in);
    wr_n_out <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    cs_n_out  <= 1'b1;
    bus_d_out <= ~{4'hf, b};
    repeat (3) @(posedge clk_sys_in);
  endtask
  task automatic read_res(input logic sel, output logic [11:0] d, output logic ok);
    int k;
    k = 0;
    @(posedge clk_sys_in);
    cs_n_out <= ~sel;
    rd_n_out <= 1'b0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (bus_oe_in !== 1'b1 && k < 10);
    d  = bus_q_in;
    ok = bus_oe_in;
    rd_n_out <= 1'b1;
    @(posedge clk_sys_in);
    cs_n_out <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
  endtask
endmodule

// File: sim/pacc_tb_top.sv
// testbench: bus-level scenarios for the converter control block
`timescale 1ns/1ps
module pacc_tb_top;
  localparam int unsigned DIV = 4;
  logic        clk_sys_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        clk_en = 1'b1;
  logic        cs_n, rd_n, wr_n, cclk, oe, done_n, trk, ok;
  logic [11:0] hd, dq, bus_w, rdat;
  logic [5:0]  oh;
  logic [1:0]  rs, ps;
  logic [71:0] ain;
  int          err_total = 0;
  int          num_checks = 0;
  int          n;
  always #50 clk_sys_in = ~clk_sys_in;
  assign bus_w = oe ? dq : hd;
  pacc_top #(.INT_CLK_DIV(DIV)) u_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en),
    .chip_select_n_in(cs_n), .read_n_in(rd_n), .write_n_in(wr_n), .conv_clk_in(cclk), .data_bus_full_in(bus_w),
    .analog_inputs_in(ain), .data_bus_full_out(dq), .data_bus_oe_out(oe), .conv_done_n_out(done_n),
    .tracking_out(trk), .channel_onehot_out(oh), .range_sel_out(rs), .power_state_out(ps));
  pacc_host_model u_host (.clk_sys_in(clk_sys_in), .bus_q_in(bus_w), .bus_oe_in(oe), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .cclk_out(cclk), .bus_d_out(hd));
  // ********
  // helpers
  // ********
  function automatic logic [11:0] chv(input int c);
    return 12'h1a5 + 12'(c) * 12'h2c3;
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_done(input int lim);
    n = 0;
    while (done_n !== 1'b0 && n < lim) begin
      @(posedge clk_sys_in);
      n++;
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_total++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    final_report;
  end
  initial begin
    for (int c = 0; c < 6; c++) ain[12*c +: 12] = chv(c);
    repeat (8) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    #1;
    chk(12'({oe, done_n, ps}), 12'h004, "reset state");
    // internal acquisition and clock, every channel and range code
    for (int c = 0; c < 6; c++) begin
      u_host.write_ctrl({2'b01, 1'b0, 1'(c >> 1), 1'(c), 3'(c)});
      wait_done(200);
      chk(12'(n >= 56 && n <= 80), 12'h001, "conversion time");
      chk(12'({rs, oh}), 12'({1'(c), 1'(c >> 1), 6'h01 << c}), "range and channel");
      if (c == 5) begin
        u_host.read_res(1'b0, rdat, ok);
        chk(12'({ok, done_n}), 12'h000, "deselected read");
      end
      u_host.read_res(1'b1, rdat, ok);
      chk(rdat, chv(c) ^ (c[0] ? 12'h800 : 12'h000), "result");
      chk(12'(done_n), 12'h001, "done after read");
    end
    u_host.write_ctrl(8'h46);
    chk(12'(oh), 12'h000, "reserved channel");
    wait_done(200);
    u_host.read_res(1'b1, rdat, ok);
    // external acquisition; input moves while open, sample must see it
    u_host.write_ctrl(8'h62);
    ain[24 +: 12] <= 12'h3c6;
    repeat (150) @(posedge clk_sys_in);
    chk(12'({trk, done_n}), 12'h003, "open acquisition");
    u_host.write_ctrl(8'h62);
    repeat (100) @(posedge clk_sys_in);
    chk(12'({trk, done_n}), 12'h003, "acquisition restarted");
    u_host.write_ctrl(8'h42);
    wait_done(200);
    chk(12'(n >= 32 && n <= 56), 12'h001, "second write converts");
    u_host.read_res(1'b1, rdat, ok);
    chk(rdat, 12'h3c6, "sample at acquisition end");
    // abort mid-conversion
    u_host.write_ctrl(8'h43);
    repeat (40) @(posedge clk_sys_in);
    u_host.write_ctrl(8'h44);
    // enable low must hold the sequencer mid-acquisition
    clk_en <= 1'b0;
    repeat (100) @(posedge clk_sys_in);
    chk(12'({trk, done_n}), 12'h003, "frozen by enable");
    clk_en <= 1'b1;
    wait_done(200);
    chk(12'(n >= 56), 12'h001, "abort restarts");
    u_host.read_res(1'b1, rdat, ok);
    chk(rdat, chv(4), "aborted result");
    // power-down waits for conversion end and keeps the clock mode
    u_host.write_ctrl(8'h81);
    chk(12'(ps), 12'h000, "standby deferred");
    wait_done(200);
    chk(12'(n <= 80), 12'h001, "clock mode kept");
    repeat (4) @(posedge clk_sys_in);
    u_host.read_res(1'b1, rdat, ok);
    chk(12'({ps, ok}), 12'h003, "standby, bus usable");
    u_host.write_ctrl(8'hc1);
    wait_done(200);
    repeat (4) @(posedge clk_sys_in);
    chk(12'(ps), 12'h003, "full power-down");
    u_host.write_ctrl(8'h01);
    chk(12'(ps), 12'h000, "write wakes");
    wait_done(400);
    chk(12'(n >= 120 && n <= 160), 12'h001, "external clock");
    final_report;
  end
endmodule

// File: sim/pacc_top_monitor.sv
// checker: port-level assertions for the converter control block
`timescale 1ns/1ps
module pacc_top_monitor #(
  parameter int unsigned INT_CLK_DIV = 4
) (
  input wire logic        clk_sys_in,
  input wire logic        reset_n_in,
  input wire logic        clk_en_in,
  input wire logic        chip_select_n_in,
  input wire logic        read_n_in,
  input wire logic        write_n_in,
  input wire logic        conv_clk_in,
  input wire logic [11:0] data_bus_full_in,
  input wire logic [71:0] analog_inputs_in,
  input wire logic [11:0] data_bus_full_out,
  input wire logic        data_bus_oe_out,
  input wire logic        conv_done_n_out,
  input wire logic        tracking_out,
  input wire logic [5:0]  channel_onehot_out,
  input wire logic [1:0]  range_sel_out,
  input wire logic [1:0]  power_state_out
);
  // ********
  // cycles since the last write strobe, saturating
  // ********
  logic [11:0] since_wr_q;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      since_wr_q <= 12'hfff;
    end else if (!write_n_in && !chip_select_n_in) begin
      since_wr_q <= 12'h000;
    end else if (since_wr_q != 12'hfff) begin
      since_wr_q <= since_wr_q + 12'h001;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  a_reset_state: assert property ($rose(reset_n_in) |-> conv_done_n_out && power_state_out == 2'h0)
    else $error("bad state after reset");
  // five cycles: pins pass two sync flops before the bus register sees them
  a_float_deselected: assert property (chip_select_n_in [*5] |-> !data_bus_oe_out)
    else $error("bus driven while deselected");
  a_read_drives: assert property ($fell(read_n_in) && !chip_select_n_in |-> ##[2:5] data_bus_oe_out)
    else $error("read not answered");
  a_read_clears: assert property ($rose(data_bus_oe_out) |-> conv_done_n_out)
    else $error("done low during read");
  a_write_clears: assert property ($rose(write_n_in) && !chip_select_n_in |-> ##[1:6] conv_done_n_out)
    else $error("done low after write");
  // a bit-5-clear byte that ends an open acquisition converts at once, no tracking
  a_write_tracks: assert property ($rose(write_n_in) && !chip_select_n_in &&
    (data_bus_full_in[5] || !tracking_out) |-> ##[2:7] tracking_out)
    else $error("no acquisition after write");
  a_track_no_done: assert property (tracking_out |-> conv_done_n_out)
    else $error("done low while tracking");
  a_no_early_done: assert property ($fell(conv_done_n_out) |-> since_wr_q >= 12'(11 * INT_CLK_DIV))
    else $error("conversion too short");
  a_range_latched: assert property ($rose(write_n_in) && !chip_select_n_in |->
    ##8 range_sel_out == {$past(data_bus_full_in[3], 8), $past(data_bus_full_in[4], 8)})
    else $error("range not latched");
  a_channel_latched: assert property ($rose(write_n_in) && !chip_select_n_in |-> ##8 channel_onehot_out ==
    (($past(data_bus_full_in[2:0], 8) < 3'h6) ? 6'h01 << $past(data_bus_full_in[2:0], 8) : 6'h00))
    else $error("channel not latched");
  a_wake_on_write: assert property ($fell(write_n_in) && !chip_select_n_in |-> ##[2:5] power_state_out == 2'h0)
    else $error("write did not wake");
endmodule
bind pacc_top pacc_top_monitor #(.INT_CLK_DIV(INT_CLK_DIV)) u_mon (
  .clk_sys_in         (clk_sys_in),
  .reset_n_in         (reset_n_in),
  .clk_en_in          (clk_en_in),
  .chip_select_n_in   (chip_select_n_in),
  .read_n_in          (read_n_in),
  .write_n_in         (write_n_in),
  .conv_clk_in        (conv_clk_in),
  .data_bus_full_in   (data_bus_full_in),
  .analog_inputs_in   (analog_inputs_in),
  .data_bus_full_out  (data_bus_full_out),
  .data_bus_oe_out    (data_bus_oe_out),
  .conv_done_n_out    (conv_done_n_out),
  .tracking_out       (tracking_out),
  .channel_onehot_out (channel_onehot_out),
  .range_sel_out      (range_sel_out),
  .power_state_out    (power_state_out)
);
